// file: src/rls_pkg.sv
package rls_pkg;

  // ----------------------------------------------------------------
  // remote / local operating states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_LOCAL,
    ST_REMOTE,
    ST_LOCAL_LOCK,
    ST_REMOTE_LOCK
  } rl_state_t;

  // ----------------------------------------------------------------
  // status commands from the command parser
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    OP_POLL,
    OP_STB_QUERY,
    OP_SRE_WRITE,
    OP_SRE_READ,
    OP_ESR_READ,
    OP_ESE_WRITE,
    OP_ESE_READ,
    OP_CLEAR_STATUS,
    OP_RESET,
    OP_DEV_CLEAR
  } op_t;

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int STB_RQS_BIT = 6;
  localparam int STB_SUM_LSB = 2;
  localparam logic [7:0] STB_SUM_MASK = 8'h3c;
  localparam logic [7:0] STB_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // event status layout
  // ----------------------------------------------------------------
  localparam int ESR_PON_BIT = 7;
  localparam int ESR_CME_BIT = 5;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_DDE_BIT = 3;
  localparam int ESR_QYE_BIT = 2;
  localparam int ESR_OPC_BIT = 0;
  localparam logic [7:0] ESR_USED_MASK = 8'hbd;
  localparam logic [15:0] ESR_RESET = 16'h0000;
  localparam logic [15:0] ESE_RESET = 16'h0000;

endpackage : rls_pkg

// file: src/rl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rl_if;
  import rls_pkg::*;
  logic      ren;
  logic      listen_addr;
  logic      go_local;
  logic      lockout;
  logic      ser_local;
  logic      ser_lockout;
  logic      ser_remote;
  logic      panel_local;
  logic      remote_cmd;
  rl_state_t state;

  modport fsm
  (
    input  ren, listen_addr, go_local, lockout, ser_local,
    input  ser_lockout, ser_remote, panel_local, remote_cmd,
    output state
  );
  modport ctl
  (
    output ren, listen_addr, go_local, lockout, ser_local,
    output ser_lockout, ser_remote, panel_local, remote_cmd,
    input  state
  );
endinterface : rl_if
`default_nettype wire

// file: src/rl_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module rl_fsm
  import rls_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  rl_if.fsm         rl
);

  typedef struct packed
  {
    rl_state_t st;
  } fsm_t;

  fsm_t s_q;
  fsm_t s_d;

  logic to_remote;
  logic to_lock;
  logic to_local;

  // ----------------------------------------------------------------
  // transitions
  // ----------------------------------------------------------------
  always_comb
  begin
    to_remote = (rl.listen_addr & rl.ren) | rl.ser_remote;
    to_lock   = (rl.lockout & rl.ren) | rl.ser_lockout;
    to_local  = rl.go_local | rl.ser_local;
    s_d = s_q;
    // in remote lockout, losing remote enable beats go-to-local in the same cycle
    case (s_q.st)
      ST_LOCAL:
      begin
        if (to_lock)
          s_d.st = ST_LOCAL_LOCK;
        else if (to_remote)
          s_d.st = ST_REMOTE;
      end
      ST_REMOTE:
      begin
        if (to_local | rl.panel_local)
          s_d.st = ST_LOCAL;
        else if (to_lock)
          s_d.st = ST_REMOTE_LOCK;
      end
      ST_LOCAL_LOCK:
      begin
        if (to_remote | rl.remote_cmd)
          s_d.st = ST_REMOTE_LOCK;
      end
      ST_REMOTE_LOCK:
      begin
        if (!rl.ren)
          s_d.st = ST_LOCAL;
        else if (to_local)
          s_d.st = ST_LOCAL_LOCK;
      end
      default:
        s_d.st = ST_LOCAL;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      s_q <= '{st: ST_LOCAL};
    else
      s_q <= s_d;
  end

  assign rl.state = s_q.st;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_no_direct_lock: assert property ((s_q.st == ST_LOCAL) |=> (s_q.st != ST_REMOTE_LOCK))
    else $error("local jumped straight to remote lockout");
  a_ren_drop_local: assert property ((s_q.st == ST_REMOTE_LOCK && !rl.ren) |=> (s_q.st == ST_LOCAL))
    else $error("remote enable drop did not return to local");
  a_lock_to_rlock: assert property ((s_q.st == ST_LOCAL_LOCK && rl.remote_cmd) |=> (s_q.st == ST_REMOTE_LOCK))
    else $error("lockout did not move to remote lockout");
  a_gtl_keeps_lock: assert property ((s_q.st == ST_REMOTE_LOCK && rl.ren && rl.go_local)
    |=> (s_q.st == ST_LOCAL_LOCK))
    else $error("go to local lost the lockout");
  c_remote_lock: cover property ((s_q.st == ST_LOCAL_LOCK) ##1 (s_q.st == ST_REMOTE_LOCK));

endmodule : rl_fsm
`default_nettype wire

// file: src/rl_status.sv
// Behaviour
// - local state executes only non-altering commands
// - lockout plus remote request gives remote lockout
// - remote enable plus listen address enters remote
// - remote ignores panel except local control
// - remote lockout only from remote or lockout
// - lockout message with remote enable locks local
// - go-to-local in remote lockout gives lockout
// - remote enable drop returns remote lockout to plain local
// - status byte layout, bits 7,1,0 zero
// - status byte clears at power-on
// - enabled summary rising edge sets service request
// - master summary is OR of enabled summaries
// - event summary from enabled event bits
// - message bit follows pending output data
// - fault bit follows non-empty fault queue
// - change summary from enabled change bits
// - service request line follows requesting flag
// - poll, clear or summary loss clears request
// - service enable clears at power-up
// - event status sixteen bits, reserved zero
// - event status clears at power-on and read
// - event bits sticky until read or clear
// - event bit positions as laid out
// - reading event enable leaves it unchanged
`timescale 1ns/1ps
`default_nettype none
module rl_status
  import rls_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_ren,
  input  wire logic        i_listen_addr,
  input  wire logic        i_go_local,
  input  wire logic        i_lockout,
  input  wire logic        i_ser_local,
  input  wire logic        i_ser_lockout,
  input  wire logic        i_ser_remote,
  input  wire logic        i_panel_local,
  input  wire logic        i_panel_req,
  input  wire logic        i_dev_cmd_req,
  input  wire logic        i_dev_cmd_alters,
  input  wire logic        i_cmd_valid,
  input  wire op_t         i_cmd_op,
  input  wire logic [15:0] i_cmd_data,
  input  wire logic        i_powered_up_event,
  input  wire logic        i_malformed_command_event,
  input  wire logic        i_execution_fault_event,
  input  wire logic        i_device_specific_fault_event,
  input  wire logic        i_query_fault_event,
  input  wire logic        i_operation_complete_event,
  input  wire logic        i_message_waiting,
  input  wire logic        i_fault_waiting,
  input  wire logic        i_instrument_change_summary,
  output logic      [1:0]  o_rl_state,
  output logic             o_local_ctl_shown,
  output logic             o_panel_grant,
  output logic             o_dev_cmd_exec,
  output logic             o_dev_cmd_refused,
  output logic             o_srq,
  output logic             o_rsp_valid,
  output logic      [15:0] o_rsp_data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0]  service_request_enable;
    logic [7:0]  event_status;
    logic [7:0]  event_status_enable;
    logic [3:0]  sum_prev;
    logic        service_requesting_flag;
    logic        rsp_valid;
    logic [15:0] rsp_data;
  } status_t;

  status_t s_q;
  status_t s_d;

  rl_if rl ();

  logic       remote;
  logic       event_summary_bit;
  logic [3:0] sum;
  logic [3:0] sum_en;
  logic [3:0] rise;
  logic       master_summary_flag;
  logic [7:0] ev;
  logic [7:0] stb_base;
  logic       poll;
  logic       cls;
  logic       clr_esr;

  // ----------------------------------------------------------------
  // remote / local state machine
  // ----------------------------------------------------------------
  assign rl.ren         = i_ren;
  assign rl.listen_addr = i_listen_addr;
  assign rl.go_local    = i_go_local;
  assign rl.lockout     = i_lockout;
  assign rl.ser_local   = i_ser_local;
  assign rl.ser_lockout = i_ser_lockout;
  assign rl.ser_remote  = i_ser_remote;
  assign rl.panel_local = i_panel_local;
  // an altering command in lockout counts as a remote request
  assign rl.remote_cmd  = i_dev_cmd_req & i_dev_cmd_alters;

  rl_fsm u_fsm
  (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .rl     (rl)
  );

  assign remote = (rl.state == ST_REMOTE) | (rl.state == ST_REMOTE_LOCK);
  assign o_rl_state = rl.state;

  // queries always run; setting changes wait for remote
  assign o_dev_cmd_exec    = i_dev_cmd_req & (remote | ~i_dev_cmd_alters);
  assign o_dev_cmd_refused = i_dev_cmd_req & ~remote & i_dev_cmd_alters;

  // power and local control are handled outside this gate
  assign o_panel_grant     = i_panel_req & ~remote;
  assign o_local_ctl_shown = (rl.state == ST_REMOTE);

  // ----------------------------------------------------------------
  // summaries
  // ----------------------------------------------------------------
  always_comb
  begin
    event_summary_bit = |(s_q.event_status & s_q.event_status_enable);
    // order matches status byte bits 5 down to 2
    sum = {event_summary_bit, i_message_waiting, i_fault_waiting,
           i_instrument_change_summary};
    sum_en = sum & s_q.service_request_enable[5:2];
    master_summary_flag = |sum_en;
    rise = sum & ~s_q.sum_prev & s_q.service_request_enable[5:2];
    stb_base = {2'b00, sum, 2'b00};
    ev = 8'h00;
    ev[ESR_PON_BIT] = i_powered_up_event;
    ev[ESR_CME_BIT] = i_malformed_command_event;
    ev[ESR_EXE_BIT] = i_execution_fault_event;
    ev[ESR_DDE_BIT] = i_device_specific_fault_event;
    ev[ESR_QYE_BIT] = i_query_fault_event;
    ev[ESR_OPC_BIT] = i_operation_complete_event;
  end

  assign poll    = i_cmd_valid && (i_cmd_op == OP_POLL);
  assign cls     = i_cmd_valid && (i_cmd_op == OP_CLEAR_STATUS);
  assign clr_esr = i_cmd_valid && ((i_cmd_op == OP_ESR_READ) || (i_cmd_op == OP_CLEAR_STATUS)
                   || (i_cmd_op == OP_RESET) || (i_cmd_op == OP_DEV_CLEAR));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.sum_prev = sum;
    // a new event in the clearing cycle survives the clear
    s_d.event_status = ((clr_esr ? 8'h00 : s_q.event_status) | ev) & ESR_USED_MASK;
    // set wins over poll or clear; loss of summary drops it
    s_d.service_requesting_flag = ((s_q.service_requesting_flag & ~poll & ~cls) | (|rise)) & master_summary_flag;
    if (i_cmd_valid)
    begin
      case (i_cmd_op)
        OP_POLL:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data = {8'h00, stb_base | {1'b0, s_q.service_requesting_flag, 6'h00}};
        end
        OP_STB_QUERY:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data = {8'h00, stb_base | {1'b0, master_summary_flag, 6'h00}};
        end
        OP_SRE_WRITE:
          s_d.service_request_enable = i_cmd_data[7:0] & STB_SUM_MASK;
        OP_SRE_READ:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data = {8'h00, s_q.service_request_enable};
        end
        OP_ESR_READ:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data = {8'h00, s_q.event_status};
        end
        OP_ESE_WRITE:
          s_d.event_status_enable = i_cmd_data[7:0] & ESR_USED_MASK;
        OP_ESE_READ:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data = {8'h00, s_q.event_status_enable};
        end
        default:
          s_d.rsp_valid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q.service_request_enable       <= SRE_RESET;
      s_q.event_status       <= ESR_RESET[7:0];
      s_q.event_status_enable       <= ESE_RESET[7:0];
      s_q.sum_prev  <= STB_RESET[5:2];
      s_q.service_requesting_flag       <= 1'b0;
      s_q.rsp_valid <= 1'b0;
      s_q.rsp_data  <= 16'h0000;
    end
    else
      s_q <= s_d;
  end

  assign o_srq       = s_q.service_requesting_flag;
  assign o_rsp_valid = s_q.rsp_valid;
  assign o_rsp_data  = s_q.rsp_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_rise_sets_rqs: assert property ((|rise) |=> o_srq)
    else $error("enabled summary rise did not request service");
  a_poll_clears: assert property ((poll && !(|rise)) |=> !o_srq)
    else $error("poll did not clear service request");
  a_mss_loss: assert property ((!master_summary_flag) |=> !o_srq)
    else $error("request held without master summary");
  a_esr_read_clr: assert property ((i_cmd_valid && i_cmd_op == OP_ESR_READ && ev == 8'h00)
    |=> (s_q.event_status == 8'h00))
    else $error("event status not cleared by read");
  a_esr_sticky: assert property ((!clr_esr) |=> ((s_q.event_status & $past(s_q.event_status)) == $past(s_q.event_status)))
    else $error("event bit dropped without a clear");
  a_esr_reserved: assert property ((s_q.event_status & ~ESR_USED_MASK) == 8'h00)
    else $error("reserved event bit set");
  a_poll_bit6: assert property (poll |=> (o_rsp_valid && o_rsp_data[6] == $past(s_q.service_requesting_flag)))
    else $error("poll bit 6 is not the request flag");
  a_query_bit6: assert property ((i_cmd_valid && i_cmd_op == OP_STB_QUERY)
    |=> (o_rsp_valid && o_rsp_data[6] == $past(master_summary_flag)))
    else $error("query bit 6 is not the master summary");
  a_ese_read_keep: assert property ((i_cmd_valid && i_cmd_op == OP_ESE_READ) |=> (s_q.event_status_enable == $past(s_q.event_status_enable)))
    else $error("event enable changed on read");
  a_stb_zero_bits: assert property ((poll || (i_cmd_valid && i_cmd_op == OP_STB_QUERY))
    |=> (o_rsp_data[7] == 1'b0 && o_rsp_data[1:0] == 2'b00))
    else $error("status byte reserved bit set");
  a_local_refuse: assert property ((!remote && i_dev_cmd_req && i_dev_cmd_alters) |-> !o_dev_cmd_exec)
    else $error("altering command ran in local");

  c_srq_poll: cover property (o_srq ##1 poll);
  c_esr_read: cover property (i_cmd_valid && i_cmd_op == OP_ESR_READ && s_q.event_status != 8'h00);
  c_mss_drop: cover property (o_srq ##1 !master_summary_flag);

endmodule : rl_status
`default_nettype wire

// file: tb/rls_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rls_host_model
  import rls_pkg::*;
(
  input  wire logic        i_mclk,
  output logic             o_ren,
  output logic      [5:0]  o_pulse,
  output logic             o_cmd_valid,
  output var op_t          o_cmd_op,
  output logic      [15:0] o_cmd_data
);
  // pulse bits: listen, go-to-local, lockout, serial local, serial lockout, serial remote
  initial
  begin
    o_ren = 1'b0;
    o_pulse = 6'h00;
    o_cmd_valid = 1'b0;
    o_cmd_op = OP_POLL;
    o_cmd_data = 16'h0000;
  end

  // one message per edge; remote enable stays a level between messages
  task automatic step(input logic r, input logic [5:0] p, input logic v, input op_t op, input logic [15:0] d);
    @(posedge i_mclk);
    o_ren <= r;
    o_pulse <= p;
    o_cmd_valid <= v;
    o_cmd_op <= op;
    o_cmd_data <= d;
  endtask : step
endmodule : rls_host_model
`default_nettype wire

// file: tb/remote_local_status_reporting_bench.sv
`timescale 1ns/1ps
`default_nettype none
module remote_local_status_reporting_bench;
  import rls_pkg::*;
  logic        i_mclk, i_nrst, ren, cmd_valid, run;
  logic [5:0]  pulse;
  logic [12:0] ins;
  op_t         cmd_op;
  logic [15:0] cmd_data, o_rsp_data, event_status, event_status_enable, rd;
  logic [1:0]  o_rl_state, st;
  logic        o_local_ctl_shown, o_panel_grant, o_dev_cmd_exec, o_dev_cmd_refused, o_srq, o_rsp_valid;
  logic [7:0]  service_request_enable, sum, psum;
  logic        flg, master_summary_flag, rv;
  int          bad_count, checked, seed;

  rls_host_model host_u (.i_mclk(i_mclk), .o_ren(ren), .o_pulse(pulse), .o_cmd_valid(cmd_valid),
    .o_cmd_op(cmd_op), .o_cmd_data(cmd_data));
  rl_status dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ren(ren), .i_listen_addr(pulse[0]),
    .i_go_local(pulse[1]), .i_lockout(pulse[2]), .i_ser_local(pulse[3]), .i_ser_lockout(pulse[4]),
    .i_ser_remote(pulse[5]), .i_panel_local(ins[12]), .i_panel_req(ins[4]), .i_dev_cmd_req(ins[11]),
    .i_dev_cmd_alters(ins[3]), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_data(cmd_data),
    .i_powered_up_event(ins[10]), .i_malformed_command_event(ins[9]), .i_execution_fault_event(ins[8]),
    .i_device_specific_fault_event(ins[7]), .i_query_fault_event(ins[6]),
    .i_operation_complete_event(ins[5]), .i_message_waiting(ins[2]), .i_fault_waiting(ins[1]),
    .i_instrument_change_summary(ins[0]), .o_rl_state(o_rl_state), .o_local_ctl_shown(o_local_ctl_shown),
    .o_panel_grant(o_panel_grant), .o_dev_cmd_exec(o_dev_cmd_exec), .o_dev_cmd_refused(o_dev_cmd_refused),
    .o_srq(o_srq), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data));

  always #5 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------
  // reference model, one step per edge on the inputs seen there
  // ----------------------------------------------------------------
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st = ST_LOCAL;
      {service_request_enable, psum, flg, rv} = '0;
      {event_status, event_status_enable, rd} = '0;
    end
    else
    begin
      sum = {2'b00, |(event_status & event_status_enable), ins[2:0], 2'b00};
      master_summary_flag = |(sum & service_request_enable);
      rv = cmd_valid && cmd_op inside {OP_POLL, OP_STB_QUERY, OP_SRE_READ, OP_ESR_READ, OP_ESE_READ};
      if (rv)
        rd = (cmd_op == OP_POLL) ? {9'h000, flg, sum[5:0]} : (cmd_op == OP_STB_QUERY) ? {9'h000, master_summary_flag, sum[5:0]}
          : (cmd_op == OP_SRE_READ) ? {8'h00, service_request_enable} : (cmd_op == OP_ESR_READ) ? event_status : event_status_enable;
      // a new enabled summary wins over a clear in the same cycle
      flg = |(sum & service_request_enable & ~psum) ? 1'b1
        : ((cmd_valid && cmd_op inside {OP_POLL, OP_CLEAR_STATUS}) || !master_summary_flag) ? 1'b0 : flg;
      event_status = ((cmd_valid && cmd_op inside {OP_ESR_READ, OP_CLEAR_STATUS, OP_RESET, OP_DEV_CLEAR}) ? 16'h0000 : event_status)
        | {8'h00, ins[10], 1'b0, ins[9:6], 1'b0, ins[5]};
      if (cmd_valid && cmd_op == OP_SRE_WRITE)
        service_request_enable = cmd_data[7:0] & 8'h3c;
      if (cmd_valid && cmd_op == OP_ESE_WRITE)
        event_status_enable = cmd_data & 16'h00bd;
      psum = sum;
      case (st)
        ST_LOCAL: st = ((pulse[2] && ren) || pulse[4]) ? ST_LOCAL_LOCK
          : ((pulse[0] && ren) || pulse[5]) ? ST_REMOTE : st;
        ST_REMOTE: st = (pulse[1] || pulse[3] || ins[12]) ? ST_LOCAL
          : ((pulse[2] && ren) || pulse[4]) ? ST_REMOTE_LOCK : st;
        ST_LOCAL_LOCK: st = ((pulse[0] && ren) || pulse[5] || (ins[11] && ins[3])) ? ST_REMOTE_LOCK : st;
        default: st = !ren ? ST_LOCAL : (pulse[1] || pulse[3]) ? ST_LOCAL_LOCK : st;
      endcase
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  always @(negedge i_mclk)
  begin
    if (run)
    begin
      chk({14'h0, o_rl_state}, {14'h0, st}, "state");
      chk({15'h0, o_local_ctl_shown}, {15'h0, st == ST_REMOTE}, "local control");
      chk({15'h0, o_panel_grant}, {15'h0, ins[4] & !st[0]}, "panel");
      chk({15'h0, o_dev_cmd_exec}, {15'h0, ins[11] & (!ins[3] | st[0])}, "exec");
      chk({15'h0, o_dev_cmd_refused}, {15'h0, ins[11] & ins[3] & !st[0]}, "refuse");
      chk({15'h0, o_srq}, {15'h0, flg}, "srq");
      chk({15'h0, o_rsp_valid}, {15'h0, rv}, "rsp valid");
      if (rv)
        chk(o_rsp_data, rd, "rsp data");
    end
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  task automatic go(input logic r, input logic [5:0] p, input logic v, input op_t op, input logic [15:0] d);
    host_u.step(r, p, v, op, d);
    host_u.step(r, 6'h00, 1'b0, OP_POLL, 16'h0000);
  endtask : go

  // pulses last one cycle, level inputs stay
  task automatic drive(input logic [12:0] v);
    @(posedge i_mclk);
    ins <= v;
    @(posedge i_mclk);
    ins <= v & 13'h001f;
  endtask : drive

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial
  begin
    // hang guard well past the longest sequence
    #100000;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    {i_mclk, i_nrst, ins, bad_count, checked} = '0;
    run = 1'b1;
    seed = 32'he953d16b;
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    for (int k = 0; k < 10; k++)
      go(1'b1, 6'h00, 1'b1, op_t'(k), 16'h0000);
    go(1'b0, 6'h04, 1'b0, OP_POLL, 16'h0000);
    go(1'b0, 6'h01, 1'b0, OP_POLL, 16'h0000);
    go(1'b1, 6'h01, 1'b0, OP_POLL, 16'h0000);
    drive(13'h0818);
    drive(13'h1000);
    go(1'b1, 6'h20, 1'b0, OP_POLL, 16'h0000);
    go(1'b1, 6'h04, 1'b0, OP_POLL, 16'h0000);
    drive(13'h1010);
    go(1'b1, 6'h02, 1'b0, OP_POLL, 16'h0000);
    drive(13'h0808);
    go(1'b0, 6'h00, 1'b0, OP_POLL, 16'h0000);
    go(1'b1, 6'h10, 1'b0, OP_POLL, 16'h0000);
    go(1'b1, 6'h01, 1'b0, OP_POLL, 16'h0000);
    go(1'b1, 6'h08, 1'b0, OP_POLL, 16'h0000);
    go(1'b1, 6'h20, 1'b0, OP_POLL, 16'h0000);
    go(1'b0, 6'h00, 1'b0, OP_POLL, 16'h0000);
    drive(13'h0808);
    drive(13'h0800);
    go(1'b1, 6'h00, 1'b1, OP_SRE_WRITE, 16'hffff);
    go(1'b1, 6'h00, 1'b1, OP_ESE_WRITE, 16'hffff);
    for (int i = 5; i < 11; i++)
    begin
      drive(13'h0001 << i);
      go(1'b1, 6'h00, 1'b1, OP_ESE_READ, 16'h0000);
    end
    go(1'b1, 6'h00, 1'b1, OP_ESR_READ, 16'h0000);
    drive(13'h0004);
    go(1'b1, 6'h00, 1'b1, OP_POLL, 16'h0000);
    go(1'b1, 6'h00, 1'b1, OP_STB_QUERY, 16'h0000);
    drive(13'h0003);
    go(1'b1, 6'h00, 1'b1, OP_CLEAR_STATUS, 16'h0000);
    repeat (400)
    begin
      host_u.step(($random(seed) & 7) != 0, 6'($random(seed) & $random(seed) & $random(seed)),
        $random(seed) & 1, op_t'(4'($unsigned($random(seed)) % 10) == OP_SRE_WRITE ? OP_POLL
        : $unsigned($random(seed)) % 10), 16'($random(seed)));
      ins <= (13'($random(seed) & $random(seed) & $random(seed)) & 13'h1fe0) | {8'h00, 5'($random(seed))};
    end
    go(1'b1, 6'h00, 1'b0, OP_POLL, 16'h0000);
    give_verdict();
  end
endmodule : remote_local_status_reporting_bench
`default_nettype wire
